// [hdl/cpmr_pkg.sv]
// shared constants, types and state layout of the programming-model register set
package cpmr_pkg;
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_IDX = 8'h04;
    localparam logic [7:0] OFS_SP = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0C;
    localparam logic [7:0] OFS_CCR = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_VECTOR = 8'h1C;

    localparam int SP_LOW_W = 6;
    localparam int PC_LOW_W = 13;
    localparam int STACK_DEPTH = 64;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [9:0] SP_FIXED_HIGH = 10'h003;
    localparam logic [2:0] PC_FIXED_HIGH = 3'h0;
    localparam logic [2:0] CCR_FIXED_HIGH = 3'h7;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] IDX_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [31:0] VECTOR_RESET = 32'h00000000;

    localparam logic [3:0] MUL_CYCLES = 4'hB;
    localparam logic [3:0] MUL_STEPS = 4'h8;
    localparam logic [3:0] BYTE_STACK_BYTES = 4'h1;
    localparam logic [3:0] CALL_STACK_BYTES = 4'h2;
    localparam logic [3:0] INT_STACK_BYTES = 4'h5;

    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ALU_LSB = 8;
    localparam int CMD_OPERAND_LSB = 16;
    localparam int VEC_HW_LSB = 0;
    localparam int VEC_SW_LSB = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PEND = 1;
    localparam int STAT_COUNT_LSB = 4;

    typedef enum logic [4:0] {
        CMD_NOP, CMD_ALU_ACC, CMD_ALU_IDX, CMD_TAX, CMD_TXA, CMD_PUSH_ACC, CMD_PULL_ACC,
        CMD_CALL, CMD_RETURN, CMD_SOFT_INT, CMD_INTERRUPT_RETURN_OP, CMD_STACK_POINTER_RELOAD_OP,
        CMD_FETCH, CMD_JUMP, CMD_EIGHT_BY_EIGHT_PRODUCT, CMD_MASK_CLEAR, CMD_MASK_SET,
        CMD_CARRY_CLEAR, CMD_CARRY_SET
    } cpmr_cmd_type;

    typedef enum logic [4:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_CMP, ALU_AND, ALU_OR, ALU_EOR, ALU_BIT, ALU_LOAD,
        ALU_INC, ALU_DEC, ALU_NEG, ALU_COM, ALU_LSL, ALU_LSR, ALU_ASR, ALU_ROL, ALU_ROR, ALU_CLR, ALU_TST
    } cpmr_alu_type;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_PUSH, SEQ_PULL, SEQ_PRODUCT} cpmr_seq_type;
    typedef enum logic [1:0] {FRAME_BYTE, FRAME_CALL, FRAME_INTERRUPT} cpmr_frame_type;

    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } cpmr_flags_type;

    typedef struct packed {
        logic [7:0] result;
        logic writeBack;
        cpmr_flags_type flags;
        cpmr_flags_type touched;
    } cpmr_alu_out_type;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] idx;
        logic [SP_LOW_W-1:0] sp;
        logic [PC_LOW_W-1:0] pc;
        cpmr_flags_type flags;
        logic [31:0] vector;
        cpmr_seq_type seq;
        cpmr_frame_type frame;
        logic swInt;
        logic [3:0] count;
        logic [PC_LOW_W-1:0] target;
        logic [15:0] product;
        logic [7:0] mcand;
        logic irqPending;
        logic ack;
        logic [31:0] rdData;
        logic [STACK_DEPTH-1:0][7:0] stack;
    } cpmr_state_type;

    localparam cpmr_state_type STATE_RESET = '{
        acc: ACC_RESET, idx: IDX_RESET, sp: SP_RESET[SP_LOW_W-1:0], pc: PC_RESET,
        flags: '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0}, vector: VECTOR_RESET,
        seq: SEQ_IDLE, frame: FRAME_BYTE, swInt: 1'b0, count: 4'h0, target: PC_RESET,
        product: 16'h0000, mcand: 8'h00, irqPending: 1'b0, ack: 1'b0, rdData: 32'h00000000,
        stack: '0
    };
endpackage : cpmr_pkg

// [hdl/cpmr_alu.sv]
// combinational arithmetic/logic unit with per-flag update mask
`timescale 1ns/10ps
module cpmr_alu
    import cpmr_pkg::*;
(
    input wire cpmr_alu_type op, // selected operation
    input wire logic [7:0] operandA, // register operand
    input wire logic [7:0] operandM, // immediate or memory operand
    input wire logic carryIn, // current carry flag
    output cpmr_alu_out_type aluOut // result, write-back and flag updates
);
    logic [8:0] sum;
    logic [8:0] diff;
    logic useCarry;

    always_comb begin
        useCarry = (op == ALU_ADC) || (op == ALU_SBC);
        sum = {1'b0, operandA} + {1'b0, operandM} + {8'h00, useCarry & carryIn};
        diff = {1'b0, operandA} - {1'b0, operandM} - {8'h00, useCarry & carryIn};
        aluOut = '0;
        aluOut.writeBack = 1'b1;
        aluOut.touched.n = 1'b1;
        aluOut.touched.z = 1'b1;
        unique case (op)
            ALU_ADD, ALU_ADC: begin
                aluOut.result = sum[7:0];
                aluOut.flags.c = sum[8];
                aluOut.flags.h = (operandA[3] & operandM[3]) | (operandM[3] & ~sum[3])
                    | (~sum[3] & operandA[3]);
                aluOut.touched.h = 1'b1;
                aluOut.touched.c = 1'b1;
            end
            ALU_SUB, ALU_SBC, ALU_CMP: begin
                aluOut.result = diff[7:0];
                aluOut.flags.c = diff[8];
                aluOut.touched.c = 1'b1;
                aluOut.writeBack = (op != ALU_CMP);
            end
            ALU_AND, ALU_BIT: begin
                aluOut.result = operandA & operandM;
                aluOut.writeBack = (op == ALU_AND);
            end
            ALU_OR: aluOut.result = operandA | operandM;
            ALU_EOR: aluOut.result = operandA ^ operandM;
            ALU_LOAD: aluOut.result = operandM;
            ALU_INC: aluOut.result = operandA + 8'h01;
            ALU_DEC: aluOut.result = operandA - 8'h01;
            ALU_NEG: begin
                aluOut.result = 8'h00 - operandA;
                aluOut.flags.c = (operandA != 8'h00);
                aluOut.touched.c = 1'b1;
            end
            ALU_COM: begin
                aluOut.result = ~operandA;
                aluOut.flags.c = 1'b1;
                aluOut.touched.c = 1'b1;
            end
            ALU_LSL, ALU_ROL: begin
                aluOut.result = {operandA[6:0], (op == ALU_ROL) & carryIn};
                aluOut.flags.c = operandA[7];
                aluOut.touched.c = 1'b1;
            end
            ALU_LSR, ALU_ASR, ALU_ROR: begin
                aluOut.result = {(op == ALU_ASR) ? operandA[7] : ((op == ALU_ROR) & carryIn), operandA[7:1]};
                aluOut.flags.c = operandA[0];
                aluOut.touched.c = 1'b1;
            end
            ALU_CLR: aluOut.result = 8'h00;
            ALU_TST: begin
                aluOut.result = operandA;
                aluOut.writeBack = 1'b0;
            end
            default: begin
                // undefined code: no write and no flag change
                aluOut.writeBack = 1'b0;
                aluOut.touched = '0;
            end
        endcase
        aluOut.flags.n = aluOut.result[7];
        aluOut.flags.z = (aluOut.result == 8'h00);
    end
endmodule : cpmr_alu

// [hdl/cpmr_regs.sv]
// programming-model registers, stack sequencer and multiply chain behind a wishbone slave
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module cpmr_regs
    import cpmr_pkg::*;
(
    input wire logic clk, // system clock, 100 MHz
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte lane selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic irqRequest, // external interrupt request, active high level
    output logic busy // sequencer running, commands ignored
);
    cpmr_state_type r;
    cpmr_state_type n;
    cpmr_alu_out_type aluOut;
    cpmr_cmd_type cmdOp;
    logic [31:0] cmdWord;
    logic [31:0] wrWord;
    logic busReq;
    logic busWrite;
    logic cmdAccepted;
    logic pendClear;
    logic [SP_LOW_W-1:0] spInc;
    logic [7:0] pulled;
    logic [8:0] stepSum;
    logic [16:0] stepWide;

    function automatic logic [31:0] applySel(input logic [31:0] oldWord, input logic [31:0] newWord,
                                             input logic [3:0] sel);
        logic [31:0] w;
        w = oldWord;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                w[8*b +: 8] = newWord[8*b +: 8];
            end
        end
        return w;
    endfunction : applySel

    function automatic logic [3:0] frameLen(input cpmr_frame_type frame);
        unique case (frame)
            FRAME_CALL: return CALL_STACK_BYTES;
            FRAME_INTERRUPT: return INT_STACK_BYTES;
            default: return BYTE_STACK_BYTES;
        endcase
    endfunction : frameLen

    function automatic logic [31:0] regRead(input cpmr_state_type st, input logic [7:0] adr);
        logic [31:0] w;
        w = 32'h00000000;
        unique case (adr)
            OFS_ACC: w = {24'h000000, st.acc};
            OFS_IDX: w = {24'h000000, st.idx};
            OFS_SP: w = {16'h0000, SP_FIXED_HIGH, st.sp};
            OFS_PC: w = {16'h0000, PC_FIXED_HIGH, st.pc};
            OFS_CCR: w = {24'h000000, CCR_FIXED_HIGH, st.flags};
            OFS_STATUS: begin
                w[STAT_BUSY] = (st.seq != SEQ_IDLE);
                w[STAT_PEND] = st.irqPending;
                w[STAT_COUNT_LSB +: 4] = st.count;
            end
            OFS_VECTOR: w = st.vector;
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction : regRead

    // byte order on the stack; pulls walk the same list backwards
    function automatic logic [7:0] pushByte(input cpmr_state_type st);
        logic [7:0] b;
        b = st.acc;
        if (st.frame == FRAME_CALL) begin
            b = (st.count == 4'h0) ? st.pc[7:0] : {PC_FIXED_HIGH, st.pc[PC_LOW_W-1:8]};
        end else if (st.frame == FRAME_INTERRUPT) begin
            unique case (st.count)
                4'h0: b = st.pc[7:0];
                4'h1: b = {PC_FIXED_HIGH, st.pc[PC_LOW_W-1:8]};
                4'h2: b = st.idx;
                4'h3: b = st.acc;
                default: b = {CCR_FIXED_HIGH, st.flags};
            endcase
        end
        return b;
    endfunction : pushByte

    assign cmdWord = applySel(32'h00000000, wb_dat_i, wb_sel_i);
    assign cmdOp = cpmr_cmd_type'(cmdWord[CMD_OP_LSB +: 5]);
    assign busReq = wb_cyc_i & wb_stb_i & ~r.ack;
    // writes land on the edge where the master sees ack
    assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;
    assign wrWord = applySel(regRead(r, wb_adr_i), wb_dat_i, wb_sel_i);
    assign cmdAccepted = busWrite && (wb_adr_i == OFS_CMD) && (r.seq == SEQ_IDLE);
    assign spInc = r.sp + 6'h01;
    assign pulled = r.stack[spInc];
    assign stepSum = {1'b0, r.product[15:8]} + {1'b0, r.mcand};
    assign stepWide = r.product[0] ? {stepSum, r.product[7:0]} : {1'b0, r.product};

    cpmr_alu u_alu (
        .op(cpmr_alu_type'(cmdWord[CMD_ALU_LSB +: 5])),
        .operandA((cmdOp == CMD_ALU_IDX) ? r.idx : r.acc),
        .operandM(cmdWord[CMD_OPERAND_LSB +: 8]),
        .carryIn(r.flags.c),
        .aluOut(aluOut)
    );

    always_comb begin
        n = r;
        pendClear = 1'b0;
        n.ack = busReq;
        if (busReq) begin
            n.rdData = regRead(r, wb_adr_i);
        end

        unique case (r.seq)
            SEQ_IDLE: begin
            end
            SEQ_PUSH: begin
                n.stack[r.sp] = pushByte(r);
                n.sp = r.sp - 6'h01;
                n.count = r.count + 4'h1;
                if (r.count == frameLen(r.frame) - 4'h1) begin
                    n.seq = SEQ_IDLE;
                    n.count = 4'h0;
                    if (r.frame == FRAME_CALL) begin
                        n.pc = r.target;
                    end else if (r.frame == FRAME_INTERRUPT) begin
                        // mask is set only after every register is on the stack
                        n.flags.i = 1'b1;
                        n.pc = r.swInt ? r.vector[VEC_SW_LSB +: PC_LOW_W] : r.vector[VEC_HW_LSB +: PC_LOW_W];
                        pendClear = ~r.swInt;
                    end
                end
            end
            SEQ_PULL: begin
                n.sp = spInc;
                n.count = r.count + 4'h1;
                unique case (r.frame)
                    FRAME_CALL: begin
                        if (r.count == 4'h0) begin
                            n.pc[PC_LOW_W-1:8] = pulled[4:0];
                        end else begin
                            n.pc[7:0] = pulled;
                        end
                    end
                    FRAME_INTERRUPT: begin
                        unique case (r.count)
                            4'h0: n.flags = cpmr_flags_type'(pulled[4:0]);
                            4'h1: n.acc = pulled;
                            4'h2: n.idx = pulled;
                            4'h3: n.pc[PC_LOW_W-1:8] = pulled[4:0];
                            default: n.pc[7:0] = pulled;
                        endcase
                    end
                    default: n.acc = pulled;
                endcase
                if (r.count == frameLen(r.frame) - 4'h1) begin
                    n.seq = SEQ_IDLE;
                    n.count = 4'h0;
                end
            end
            SEQ_PRODUCT: begin
                n.count = r.count + 4'h1;
                if (r.count < MUL_STEPS) begin
                    n.product = stepWide[16:1];
                end
                if (r.count == MUL_CYCLES - 4'h1) begin
                    n.idx = r.product[15:8];
                    n.acc = r.product[7:0];
                    n.flags.h = 1'b0;
                    n.flags.c = 1'b0;
                    n.seq = SEQ_IDLE;
                    n.count = 4'h0;
                end
            end
        endcase

        if (cmdAccepted) begin
            unique case (cmdOp)
                CMD_NOP: begin
                end
                CMD_ALU_ACC, CMD_ALU_IDX: begin
                    if (aluOut.writeBack && cmdOp == CMD_ALU_ACC) begin
                        n.acc = aluOut.result;
                    end
                    if (aluOut.writeBack && cmdOp == CMD_ALU_IDX) begin
                        n.idx = aluOut.result;
                    end
                    n.flags = cpmr_flags_type'((aluOut.flags & aluOut.touched)
                        | (r.flags & ~aluOut.touched));
                end
                CMD_TAX: n.idx = r.acc;
                CMD_TXA: n.acc = r.idx;
                CMD_PUSH_ACC, CMD_CALL, CMD_SOFT_INT: begin
                    n.seq = SEQ_PUSH;
                    n.count = 4'h0;
                    n.frame = (cmdOp == CMD_PUSH_ACC) ? FRAME_BYTE : (cmdOp == CMD_CALL) ? FRAME_CALL : FRAME_INTERRUPT;
                    n.swInt = 1'b1;
                    n.target = cmdWord[CMD_OPERAND_LSB +: PC_LOW_W];
                end
                CMD_PULL_ACC, CMD_RETURN, CMD_INTERRUPT_RETURN_OP: begin
                    n.seq = SEQ_PULL;
                    n.count = 4'h0;
                    n.frame = (cmdOp == CMD_PULL_ACC) ? FRAME_BYTE : (cmdOp == CMD_RETURN) ? FRAME_CALL : FRAME_INTERRUPT;
                end
                CMD_STACK_POINTER_RELOAD_OP: n.sp = SP_RESET[SP_LOW_W-1:0];
                CMD_FETCH: n.pc = r.pc + 13'h0001;
                CMD_JUMP: n.pc = cmdWord[CMD_OPERAND_LSB +: PC_LOW_W];
                CMD_EIGHT_BY_EIGHT_PRODUCT: begin
                    n.seq = SEQ_PRODUCT;
                    n.count = 4'h0;
                    n.product = {8'h00, r.acc};
                    n.mcand = r.idx;
                end
                CMD_MASK_CLEAR: n.flags.i = 1'b0;
                CMD_MASK_SET: n.flags.i = 1'b1;
                CMD_CARRY_CLEAR: n.flags.c = 1'b0;
                CMD_CARRY_SET: n.flags.c = 1'b1;
                default: begin
                end
            endcase
        end else if (r.seq == SEQ_IDLE && r.irqPending && !r.flags.i) begin
            // a command issued this cycle goes first; the request waits until the sequencer is idle again
            n.seq = SEQ_PUSH;
            n.count = 4'h0;
            n.frame = FRAME_INTERRUPT;
            n.swInt = 1'b0;
        end

        if (busWrite) begin
            unique case (wb_adr_i)
                OFS_ACC: n.acc = wrWord[7:0];
                OFS_IDX: n.idx = wrWord[7:0];
                OFS_SP: n.sp = wrWord[SP_LOW_W-1:0];
                OFS_PC: n.pc = wrWord[PC_LOW_W-1:0];
                OFS_CCR: n.flags = cpmr_flags_type'(wrWord[4:0]);
                OFS_VECTOR: n.vector = wrWord;
                default: begin
                end
            endcase
        end

        // a new request in the clearing cycle survives
        n.irqPending = irqRequest | (r.irqPending & ~pendClear);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= STATE_RESET;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o = r.rdData;
    assign wb_ack_o = r.ack;
    assign busy = (r.seq != SEQ_IDLE);
endmodule : cpmr_regs

// [tb/cpmr_regs_monitor.sv]
// concurrent checks on the register set's bus and sequencer ports
`timescale 1ns/10ps
module cpmr_regs_monitor
    import cpmr_pkg::*;
(
    input wire logic clk, // clock
    input wire logic reset_n, // async reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [3:0] wb_sel_i, // lanes
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic irqRequest, // interrupt request
    input wire logic busy // sequencer running
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic rdAck;
    logic cmdAck;
    assign rdAck = wb_ack_o && !wb_we_i;
    // refused commands while busy must not arm the length checks
    assign cmdAck = wb_ack_o && wb_we_i && wb_adr_i == OFS_CMD && wb_sel_i[0] && !busy;
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    sp_page_a: assert property (rdAck && wb_adr_i == OFS_SP |-> wb_dat_o[31:6] == 26'h3)
        else $error("stack pointer high bits wrong");
    pc_high_a: assert property (rdAck && wb_adr_i == OFS_PC |-> wb_dat_o[31:13] == 19'h0)
        else $error("program counter high bits wrong");
    ccr_high_a: assert property (rdAck && wb_adr_i == OFS_CCR |-> wb_dat_o[31:5] == 27'h7)
        else $error("flag register high bits wrong");
    product_len_a: assert property (cmdAck && wb_dat_i[4:0] == 5'hE |=> busy [*8] ##1 busy [*3] ##1 !busy)
        else $error("product length wrong");
    int_frame_a: assert property (cmdAck && wb_dat_i[4:0] == 5'h9 |=> busy [*5] ##1 !busy)
        else $error("interrupt frame length wrong");
    call_frame_a: assert property (cmdAck && wb_dat_i[4:0] == 5'h7 |=> busy [*2] ##1 !busy)
        else $error("call frame length wrong");
    push_step_a: assert property (cmdAck && wb_dat_i[4:0] == 5'h5 |=> busy ##1 !busy)
        else $error("push length wrong");
    cover property (cmdAck && wb_dat_i[4:0] == 5'hE);
    cover property (cmdAck && wb_dat_i[4:0] == 5'h9);
    cover property ($rose(irqRequest) ##[1:20] busy);
endmodule : cpmr_regs_monitor

// [tb/cpmr_irq_source.sv]
// interrupt source model: raises the request level for a few cycles per trigger
`timescale 1ns/10ps
module cpmr_irq_source #(
    parameter int HOLD = 2
) (
    input wire logic clk, // clock
    input wire logic reset_n, // async reset
    input wire logic fire, // one-cycle trigger from the bench
    output logic irqRequest // request level to the register set
);
    logic [3:0] holdCnt_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) holdCnt_reg <= 4'h0;
        else if (fire) holdCnt_reg <= HOLD[3:0];
        else if (holdCnt_reg != 4'h0) holdCnt_reg <= holdCnt_reg - 4'h1;
    end
    assign irqRequest = holdCnt_reg != 4'h0;
endmodule : cpmr_irq_source

// [tb/cpmr_regs_tb_top.sv]
// self-checking bench for the programming-model register set
`timescale 1ns/10ps
module cpmr_regs_tb_top
    import cpmr_pkg::*;
    ;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic ack;
    logic busy;
    logic irqRequest;
    logic irqFire = 1'b0;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    cpmr_regs dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irqRequest(irqRequest), .busy(busy));
    cpmr_irq_source #(.HOLD(2)) irqSrc (.clk(clk), .reset_n(reset_n), .fire(irqFire), .irqRequest(irqRequest));
    initial forever #5 clk = ~clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic wb_cycle(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb_cycle
    task automatic chk(logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d); wb_cycle(1'b1, a, d); endtask : wr
    task automatic rc(logic [7:0] a, logic [31:0] e);
        wb_cycle(1'b0, a, 32'h0);
        chk(got, e);
    endtask : rc
    // commands issued while busy are dropped, so always wait for idle
    task automatic run(cpmr_cmd_type c, cpmr_alu_type o, logic [15:0] p);
        wb_cycle(1'b1, OFS_CMD, {p, 3'h0, o, 3'h0, c});
        repeat (3) @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
    endtask : run
    function automatic logic [31:0] fix_exp(int k, logic [31:0] v);
        case (k)
            2: return {26'h3, v[5:0]};
            3: return {19'h0, v[12:0]};
            4: return {27'h7, v[4:0]};
            default: return {24'h0, v[7:0]};
        endcase
    endfunction : fix_exp
    function automatic logic [15:0] alu_exp(logic [7:0] a, logic [7:0] m, logic sub, logic [4:0] f);
        logic [8:0] s;
        logic h;
        s = sub ? {1'b0, a} - {1'b0, m} : {1'b0, a} + {1'b0, m};
        h = sub ? f[4] : ({1'b0, a[3:0]} + {1'b0, m[3:0]}) > 5'h0F;
        return {s[7:0], 3'h7, h, f[3], s[7], s[7:0] == 8'h00, s[8]};
    endfunction : alu_exp
    initial begin
        logic [7:0] a;
        logic [7:0] m;
        logic [31:0] r;
        logic [12:0] p;
        logic [12:0] q;
        void'($urandom(32'hBF9A));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rc(OFS_SP, 32'hFF);
        rc(OFS_CCR, 32'hE8);
        rc(8'h20, 32'h0);
        for (int i = 0; i < 5; i++) begin
            r = $urandom;
            wr(8'(i * 4), r);
            rc(8'(i * 4), fix_exp(i, r));
        end
        $display("test reset_and_fields done");
        for (int i = 0; i < 8; i++) begin
            {a, m} = (i == 0) ? 16'h0F01 : (i == 1) ? 16'h8080 : (i == 4) ? 16'h0001 : 16'($urandom);
            wr(OFS_ACC, {24'h0, a});
            r = $urandom;
            wr(OFS_CCR, r);
            rc(OFS_CCR, {27'h7, r[4:0]});
            run(CMD_ALU_ACC, (i < 4) ? ALU_ADD : ALU_SUB, {8'h0, m});
            r = {16'h0, alu_exp(a, m, i >= 4, r[4:0])};
            rc(OFS_ACC, {24'h0, r[15:8]});
            rc(OFS_CCR, {24'h0, r[7:0]});
        end
        $display("test alu_flags done");
        wr(OFS_PC, 32'h1FFF);
        run(CMD_FETCH, ALU_ADD, 16'h0);
        rc(OFS_PC, 32'h0);
        q = 13'($urandom);
        run(CMD_JUMP, ALU_ADD, {3'h0, q});
        rc(OFS_PC, {19'h0, q});
        wr(OFS_SP, 32'h05);
        run(CMD_STACK_POINTER_RELOAD_OP, ALU_ADD, 16'h0);
        rc(OFS_SP, 32'hFF);
        a = 8'($urandom);
        wr(OFS_ACC, {24'h0, a});
        run(CMD_PUSH_ACC, ALU_ADD, 16'h0);
        rc(OFS_SP, 32'hFE);
        wr(OFS_ACC, 32'h0);
        run(CMD_PULL_ACC, ALU_ADD, 16'h0);
        rc(OFS_ACC, {24'h0, a});
        for (int i = 0; i < 64; i++) run(CMD_PUSH_ACC, ALU_ADD, 16'h0);
        rc(OFS_SP, 32'hFF);
        $display("test stack done");
        p = 13'($urandom);
        wr(OFS_PC, {19'h0, p});
        run(CMD_CALL, ALU_ADD, {3'h0, q});
        rc(OFS_SP, 32'hFD);
        rc(OFS_PC, {19'h0, q});
        run(CMD_RETURN, ALU_ADD, 16'h0);
        rc(OFS_PC, {19'h0, p});
        wr(OFS_VECTOR, {3'h0, q, 3'h0, ~p});
        wr(OFS_CCR, 32'h0);
        run(CMD_SOFT_INT, ALU_ADD, 16'h0);
        rc(OFS_SP, 32'hFA);
        rc(OFS_CCR, 32'hE8);
        run(CMD_INTERRUPT_RETURN_OP, ALU_ADD, 16'h0);
        rc(OFS_CCR, 32'hE0);
        rc(OFS_PC, {19'h0, p});
        $display("test call_and_swi done");
        run(CMD_MASK_SET, ALU_ADD, 16'h0);
        @(posedge clk) irqFire <= 1'b1;
        @(posedge clk) irqFire <= 1'b0;
        repeat (4) @(posedge clk);
        wb_cycle(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, got[STAT_PEND]}, 32'h1);
        rc(OFS_PC, {19'h0, p});
        run(CMD_MASK_CLEAR, ALU_ADD, 16'h0);
        rc(OFS_PC, {19'h0, ~p});
        rc(OFS_SP, 32'hFA);
        rc(OFS_CCR, 32'hE8);
        run(CMD_CARRY_SET, ALU_ADD, 16'h0);
        rc(OFS_CCR, 32'hE9);
        // accumulator still holds the byte pulled in the stack test
        run(CMD_TAX, ALU_ADD, 16'h0);
        run(CMD_ALU_IDX, ALU_INC, 16'h0);
        rc(OFS_IDX, {24'h0, a + 8'h01});
        $display("test external_irq done");
        for (int i = 0; i < 4; i++) begin
            {a, m} = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(OFS_ACC, {24'h0, a});
            wr(OFS_IDX, {24'h0, m});
            run(CMD_EIGHT_BY_EIGHT_PRODUCT, ALU_ADD, 16'h0);
            r = {24'h0, a} * {24'h0, m};
            rc(OFS_IDX, {24'h0, r[15:8]});
            rc(OFS_ACC, {24'h0, r[7:0]});
        end
        $display("test product done");
        give_verdict();
    end
endmodule : cpmr_regs_tb_top
bind cpmr_regs cpmr_regs_monitor mon (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irqRequest(irqRequest), .busy(busy));
